// ### core/dmairq_gen.v
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "dmairq_defs.vh"

module dmairq_gen (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    input wire [7:0] xfer_beat,
    output wire [7:0] transfer_done_irq,
    output wire [7:0] half_done_irq,
    output wire [7:0] chan_top_is_done,
    output wire irq
);

    // ======================================================
    // Register decode
    wire wr_ctrl;
    wire wr_chsel;
    wire wr_cnt;
    wire wr_flg;
    wire wr_stat;
    wire wr_mask;

    assign wr_ctrl = wr_en && (addr == `DMAIRQ_OFF_CTRL);
    assign wr_chsel = wr_en && (addr == `DMAIRQ_OFF_CHSEL);
    assign wr_cnt = wr_en && (addr == `DMAIRQ_OFF_COUNT);
    assign wr_flg = wr_en && (addr == `DMAIRQ_OFF_FLAGS);
    assign wr_stat = wr_en && (addr == `DMAIRQ_OFF_IRQSTAT);
    assign wr_mask = wr_en && (addr == `DMAIRQ_OFF_IRQMASK);

    // ======================================================
    // Per-channel state, gathered from the channel engines
    wire [7:0] ch_en;
    wire [7:0] done_irq_enable;
    wire [7:0] half_irq_enable;
    wire [7:0] half_flag;
    wire [7:0] done_flag;
    wire [15:0] count [0:7];
    wire [15:0] moved [0:7];

    // ======================================================
    // Shared registers
    reg [2:0] chsel;
    reg [2:0] next_chsel;
    reg [15:0] irq_mask;
    reg [15:0] next_mask;
    reg [15:0] irq_stat;
    reg [15:0] next_stat;
    reg [15:0] ev_q;
    reg [31:0] next_rdata;
    wire [15:0] ev_raw;
    wire [15:0] rising;
    wire [4:0] sel_ctrl;
    wire [31:0] sel_count;

    // ======================================================
    // Request outputs
    // Requests are pure combinational gating so a cleared flag
    // drops its request in the same cycle the flag falls
    assign transfer_done_irq = done_flag & done_irq_enable;
    assign half_done_irq = half_flag & half_irq_enable;
    // Fixed in-channel ranking; no ordering across channels is
    // applied, that is left to the interrupt controller
    assign chan_top_is_done = transfer_done_irq;

    // ======================================================
    // Channel engines
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_ch
            reg en_r;
            reg done_ie_r;
            reg half_ie_r;
            reg half_r;
            reg done_r;
            reg [15:0] count_r;
            reg [15:0] moved_r;
            reg next_en;
            reg next_done_ie;
            reg next_half_ie;
            reg next_half;
            reg next_done;
            reg [15:0] next_count;
            reg [15:0] next_moved;
            wire sel;
            wire live;
            wire [15:0] nxt;
            wire [15:0] half_point;
            wire hit_half;
            wire hit_done;
            wire clr_half;
            wire clr_done;
            wire restart;

            assign sel = ({29'h0, chsel} == g);
            // Beats are ignored while the done flag stands, so an
            // overrun cannot move the count past its end
            assign live = en_r && xfer_beat[g] && !done_r;
            assign nxt = moved_r + 16'h0001;
            assign half_point = {1'b0, count_r[15:1]};
            assign hit_half = live && (nxt == half_point) &&
                (count_r > 16'h0001);
            assign hit_done = live && (nxt == count_r);
            assign restart = wr_ctrl && sel && wdata[`DMAIRQ_CTRL_EN] &&
                !en_r;
            assign clr_half = (wr_ctrl && sel && !wdata[`DMAIRQ_CTRL_HALF]) ||
                (wr_flg && !wdata[g + 8]);
            assign clr_done = (wr_ctrl && sel && !wdata[`DMAIRQ_CTRL_DONE]) ||
                (wr_flg && !wdata[g]);

            always @* begin
                next_en = en_r;
                next_done_ie = done_ie_r;
                next_half_ie = half_ie_r;
                if (wr_ctrl && sel) begin
                    next_en = wdata[`DMAIRQ_CTRL_EN];
                    next_done_ie = wdata[`DMAIRQ_CTRL_DONE_IE];
                    next_half_ie = wdata[`DMAIRQ_CTRL_HALF_IE];
                end
            end

            always @* begin
                next_count = count_r;
                next_moved = moved_r;
                if (wr_cnt && sel) begin
                    next_count = wdata[15:0];
                    next_moved = 16'h0000;
                end else if (restart) begin
                    next_moved = 16'h0000;
                end else if (live) begin
                    next_moved = nxt;
                end
            end

            // Set beats a same-cycle software clear
            always @* begin
                next_half = half_r;
                if (hit_half) begin
                    next_half = 1'b1;
                end else if (clr_half) begin
                    next_half = 1'b0;
                end
            end

            always @* begin
                next_done = done_r;
                if (hit_done) begin
                    next_done = 1'b1;
                end else if (clr_done) begin
                    next_done = 1'b0;
                end
            end

            always @(posedge mclk) begin
                if (!rst_n) begin
                    en_r <= 1'b0;
                    done_ie_r <= 1'b0;
                    half_ie_r <= 1'b0;
                end else begin
                    en_r <= next_en;
                    done_ie_r <= next_done_ie;
                    half_ie_r <= next_half_ie;
                end
            end

            always @(posedge mclk) begin
                if (!rst_n) begin
                    count_r <= `DMAIRQ_RST_COUNT;
                    moved_r <= 16'h0000;
                end else begin
                    count_r <= next_count;
                    moved_r <= next_moved;
                end
            end

            always @(posedge mclk) begin
                if (!rst_n) begin
                    half_r <= 1'b0;
                    done_r <= 1'b0;
                end else begin
                    half_r <= next_half;
                    done_r <= next_done;
                end
            end

            assign ch_en[g] = en_r;
            assign done_irq_enable[g] = done_ie_r;
            assign half_irq_enable[g] = half_ie_r;
            assign half_flag[g] = half_r;
            assign done_flag[g] = done_r;
            assign count[g] = count_r;
            assign moved[g] = moved_r;
        end
    endgenerate

    // ======================================================
    // Event status
    // Status bits latch request rises, so enabling a request whose
    // flag already stands also counts as an event
    assign ev_raw = {half_done_irq, transfer_done_irq};
    assign rising = ev_raw & ~ev_q;

    always @(posedge mclk) begin
        if (!rst_n) begin
            ev_q <= 16'h0000;
        end else begin
            ev_q <= ev_raw;
        end
    end

    always @* begin
        next_stat = irq_stat | rising;
        // Write-one-to-clear, new events win over the clear
        if (wr_stat) begin
            next_stat = (irq_stat & ~wdata[15:0]) | rising;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            irq_stat <= 16'h0000;
        end else begin
            irq_stat <= next_stat;
        end
    end

    // ======================================================
    // Channel select and mask
    always @* begin
        next_chsel = chsel;
        if (wr_chsel) begin
            next_chsel = wdata[2:0];
        end
    end

    always @* begin
        next_mask = irq_mask;
        if (wr_mask) begin
            next_mask = wdata[15:0];
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            chsel <= 3'h0;
            irq_mask <= `DMAIRQ_RST_MASK;
        end else begin
            chsel <= next_chsel;
            irq_mask <= next_mask;
        end
    end

    // One level line for software; the per-channel requests above
    // are what the interrupt controller ranks
    assign irq = |(irq_stat & irq_mask);

    // ======================================================
    // Register read
    assign sel_ctrl = {done_flag[chsel], half_flag[chsel],
        half_irq_enable[chsel], done_irq_enable[chsel], ch_en[chsel]};
    assign sel_count = {moved[chsel], count[chsel]};

    always @* begin
        next_rdata = 32'h00000000;
        if (rd_en) begin
            case (addr)
                `DMAIRQ_OFF_CTRL: begin
                    next_rdata = {27'h0, sel_ctrl};
                end
                `DMAIRQ_OFF_CHSEL: begin
                    next_rdata = {29'h0, chsel};
                end
                `DMAIRQ_OFF_COUNT: begin
                    next_rdata = sel_count;
                end
                `DMAIRQ_OFF_FLAGS: begin
                    next_rdata = {16'h0, half_flag, done_flag};
                end
                `DMAIRQ_OFF_IRQSTAT: begin
                    next_rdata = {16'h0, irq_stat};
                end
                `DMAIRQ_OFF_IRQMASK: begin
                    next_rdata = {16'h0, irq_mask};
                end
                `DMAIRQ_OFF_REQS: begin
                    next_rdata = {16'h0, ev_raw};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Read data stand one cycle only; idle cycles read as zero
    always @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

// ### core/dmairq_defs.vh
`ifndef DMAIRQ_DEFS_VH
`define DMAIRQ_DEFS_VH

// ==========================================================
// Geometry
`define DMAIRQ_NCH 8
`define DMAIRQ_AW 4
`define DMAIRQ_CNTW 16

// ==========================================================
// Register offsets (word index, byte address = 4 * index)
`define DMAIRQ_OFF_CTRL 4'h0
`define DMAIRQ_OFF_CHSEL 4'h1
`define DMAIRQ_OFF_COUNT 4'h2
`define DMAIRQ_OFF_FLAGS 4'h3
`define DMAIRQ_OFF_IRQSTAT 4'h4
`define DMAIRQ_OFF_IRQMASK 4'h5
`define DMAIRQ_OFF_REQS 4'h6

// ==========================================================
// Channel control register fields
`define DMAIRQ_CTRL_EN 0
`define DMAIRQ_CTRL_DONE_IE 1
`define DMAIRQ_CTRL_HALF_IE 2
`define DMAIRQ_CTRL_HALF 3
`define DMAIRQ_CTRL_DONE 4

// ==========================================================
// Reset values
`define DMAIRQ_RST_CTRL 5'h00
`define DMAIRQ_RST_COUNT 16'h0000
`define DMAIRQ_RST_MASK 16'h0000

`endif

// ### tb/dmairq_chk_checker.sv
`timescale 1ns/1ns
// ====
// Request checks
module dmairq_chk (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire [7:0] xfer_beat,
    input wire [7:0] transfer_done_irq,
    input wire [7:0] half_done_irq,
    input wire [7:0] chan_top_is_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence flag_clr;
        wr_en && addr == 4'h3 && xfer_beat == 8'h00;
    endsequence
    top_rank_a: assert property (
        chan_top_is_done == transfer_done_irq)
        else $error("top request differs from done request");
    done_cause_a: assert property (
        !wr_en |=> (transfer_done_irq & ~$past(transfer_done_irq) &
        ~$past(xfer_beat)) == 8'h00)
        else $error("done request rose without a beat");
    half_cause_a: assert property (
        !wr_en |=> (half_done_irq & ~$past(half_done_irq) &
        ~$past(xfer_beat)) == 8'h00)
        else $error("half request rose without a beat");
    done_hold_a: assert property (
        !wr_en |=> (transfer_done_irq & $past(transfer_done_irq)) ==
        $past(transfer_done_irq))
        else $error("done request dropped without a write");
    half_hold_a: assert property (
        !wr_en |=> (half_done_irq & $past(half_done_irq)) ==
        $past(half_done_irq))
        else $error("half request dropped without a write");
    flag_clear_a: assert property (flag_clr |=>
        (transfer_done_irq & ~$past(wdata[7:0])) == 8'h00 &&
        (half_done_irq & ~$past(wdata[15:8])) == 8'h00)
        else $error("request stayed after flag clear");
    req_quiet_a: assert property (!wr_en && xfer_beat == 8'h00 |=>
        $stable(transfer_done_irq) && $stable(half_done_irq))
        else $error("request moved with no cause");
endmodule
bind dmairq_gen dmairq_chk chk_u (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .xfer_beat(xfer_beat),
    .transfer_done_irq(transfer_done_irq), .half_done_irq(half_done_irq),
    .chan_top_is_done(chan_top_is_done));

// ### tb/dmairq_intc.sv
`timescale 1ns/1ns
// ====
// Interrupt controller stand-in
module dmairq_intc (
    input wire mclk,
    input wire [7:0] done_req,
    input wire [7:0] half_req,
    output reg [15:0] seen
);
    // Keeps every line apart and ranks no channels; it only records each line that has been high
    initial seen = 16'h0000;
    always @(posedge mclk) begin
        seen <= seen | {half_req, done_req};
    end
endmodule

// ### tb/dmairq_gen_tb.sv
`timescale 1ns/1ns
// ====
// Bench
module dmairq_gen_tb;
    reg mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, was_rd = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg [31:0] exp_q[$];
    reg [7:0] xfer_beat = 8'h00;
    wire [31:0] rdata;
    wire [7:0] tdi, hdi, top;
    wire irq;
    wire [15:0] seen;
    integer miscompares = 0, tests_run = 0, ch, n;
    dmairq_gen dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .xfer_beat(xfer_beat), .transfer_done_irq(tdi),
        .half_done_irq(hdi), .chan_top_is_done(top), .irq(irq));
    dmairq_intc intc_u (.mclk(mclk), .done_req(tdi), .half_req(hdi),
        .seen(seen));
    initial forever #5 mclk = ~mclk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("tests_run %0d miscompares %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task acc(input r, input [3:0] a, input [31:0] d);
        begin
            addr <= a;
            wdata <= d;
            rd_en <= r;
            wr_en <= !r;
            if (r) exp_q.push_back(d);
            @(posedge mclk);
        end
    endtask
    // Strobes drop only when no access follows at the same edge
    task idle;
        begin
            rd_en <= 1'b0;
            wr_en <= 1'b0;
        end
    endtask
    task bt(input integer k);
        begin
            idle;
            repeat (k) begin
                xfer_beat <= 8'h01 << ch;
                @(posedge mclk);
            end
            xfer_beat <= 8'h00;
        end
    endtask
    task lv(input [7:0] d, input [7:0] h, input i);
        begin
            idle;
            @(negedge mclk);
            chk({top, tdi}, {d, d});
            chk(hdi, h);
            chk(irq, i);
            @(posedge mclk);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (was_rd) begin
            if (exp_q.size() > 0) begin
                chk(rdata, exp_q.pop_front());
            end else begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0t read with nothing expected", $time);
            end
        end
        was_rd <= rd_en;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares = miscompares + 1;
        results;
    end
    initial begin
        n = $urandom(32'h0d6a66e2);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        lv(8'h00, 8'h00, 1'b0);
        for (ch = 0; ch < 8; ch = ch + 1) begin
            n = 2 * (1 + $urandom % 4);
            acc(0, 4'h1, ch);
            acc(0, 4'h2, n);
            acc(0, 4'h0, 32'h7);
            bt(n / 2);
            lv(8'h00, 8'h01 << ch, 1'b0);
            // One beat past the end must be ignored
            bt(n / 2 + 1);
            lv(8'h01 << ch, 8'h01 << ch, 1'b0);
            acc(1, 4'h2, {n[15:0], n[15:0]});
            acc(1, 4'h6, 32'h101 << ch);
            acc(1, 4'h4, 32'h101 << ch);
            acc(0, 4'h5, 32'hFFFF);
            lv(8'h01 << ch, 8'h01 << ch, 1'b1);
            acc(0, 4'h4, 32'hFFFF);
            acc(0, 4'h5, 32'h0);
            acc(0, 4'h3, 32'h0);
            lv(8'h00, 8'h00, 1'b0);
            acc(1, 4'h0, 32'h7);
            acc(1, 4'hF, 32'h0);
        end
        idle;
        repeat (2) @(posedge mclk);
        chk(seen, 16'hFFFF);
        results;
    end
endmodule
